//--- fesl_consts.vh
`ifndef FESL_CONSTS_VH
`define FESL_CONSTS_VH
// APB register byte offsets
`define FESL_REG_CMD 8'h00
`define FESL_REG_ADDR 8'h04
`define FESL_REG_RDATA 8'h08
`define FESL_REG_STATUS 8'h0C
`define FESL_REG_RCR 8'h10
`define FESL_REG_PINS 8'h14
// Command word fields
`define FESL_CODE_MSB 7
`define FESL_BLK_MSB 10
`define FESL_BLK_LSB 8
`define FESL_DAT_LSB 16
// Command codes
`define FESL_C_READ_ARRAY 8'hFF
`define FESL_C_READ_STATUS 8'h70
`define FESL_C_READ_ID 8'h90
`define FESL_C_CFI 8'h98
`define FESL_C_CLR_STATUS 8'h50
`define FESL_C_PROG_SETUP 8'h40
`define FESL_C_PROG_ALT 8'h10
`define FESL_C_ERASE_SETUP 8'h20
`define FESL_C_CONFIRM 8'hD0
`define FESL_C_SUSPEND 8'hB0
`define FESL_C_LOCK_SETUP 8'h60
`define FESL_C_LOCK 8'h01
`define FESL_C_LOCKDN 8'h2F
`define FESL_C_RCR_SET 8'h03
// Status flag bit positions
`define FESL_SR_READY 7
`define FESL_SR_ESUSP 6
`define FESL_SR_ERASE_ERR 5
`define FESL_SR_PROG_ERR 4
`define FESL_SR_VPP_ERR 3
`define FESL_SR_PSUSP 2
`define FESL_SR_LOCK_ERR 1
`define FESL_SR_ERASING 0
// Reset values
`define FESL_LOCK_RST 8'hFF
`define FESL_RCR_RST 16'hBFCF
`define FESL_CFI_WORD 16'h0051
// Timing: clock period and operation times in ns
`define FESL_CLK_NS 20
`define FESL_PROG_NS 2000
`define FESL_ERASE_NS 40000
`define FESL_SUSP_NS 400
// Cycle counts: operation times above over the clock period, sized to the counters
`define FESL_PROG_CYC 12'h064
`define FESL_ERASE_CYC 12'h7D0
`define FESL_SUSP_CYC 12'h014
`endif

//--- fesl_host.sv
`default_nettype none
module fesl_host (
	// Bench side
	input wire logic pclk,
	input wire logic req,
	input wire logic wr,
	input wire logic [7:0] addr,
	input wire logic [31:0] wdata,
	output var logic ack,
	output var logic [31:0] rdata,
	output var logic err,
	// APB master
	output var logic psel,
	output var logic penable,
	output var logic pwrite,
	output var logic [7:0] paddr,
	output var logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		{ack, psel, penable, pwrite, err} = 5'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		rdata = 32'h0;
	end
	// A toggle of req starts one transfer, ack toggles at its end
	always @(posedge pclk)
		if (!psel && req != ack)
		begin
			psel <= 1'b1;
			pwrite <= wr;
			paddr <= addr;
			pwdata <= wdata;
		end
		else if (psel && !penable)
			penable <= 1'b1;
		else if (psel && pready)
		begin
			psel <= 1'b0;
			penable <= 1'b0;
			rdata <= prdata;
			err <= pslverr;
			ack <= ~ack;
		end
endmodule // fesl_host
`default_nettype wire

//--- fesl_sequencer.v
// Summary of operation
// - Program resume continues the suspended program, clearing ready and program-suspended flags.
// - Program and erase resume are accepted at any block address.
// - Supply at lockout level halts program or erase and sets the supply error flag.
// - Lock bits stay writable and readable whatever the programming supply level.
// - One erase sequence erases exactly one whole block, leaving it all ones.
// - Chip enable going inactive during erase lets the erase finish before standby.
// - After an erase command reads return status until a later read command is accepted.
// - Erasing flag shows the addressed block erasing; ready sets at erase completion.
// - Erase end reports failure, supply error, or locked-block abort flags.
// - Erase suspend stops at a checkpoint, keeps status, sets ready and erase-suspended.
// - During erase suspend, program and read any block except the suspended one.
// - Erase suspend accepts reads, status, id, query, resume, clear, program, lock commands.
// - Erase resumes only after programs started during the suspend complete.
// - Erase resume continues erase, clearing ready and erase-suspended flags.
// - Reset during erase suspend resets the device; reset stays off across resume.
// - All blocks locked after reset; locked blocks refuse program and erase.
// - After lock setup the next block command sets its lock, or loads read configuration.
// - Locked-down block unlocks only with write-protect deasserted; reset returns it locked.
// - Identifier read returns lock bit on bit zero and lock-down bit on bit one.
// - Lock setup followed by other commands sets program and erase error flags.
// - Lock changes refused in program suspend; suspended-erase block lock applies immediately.
//
// Added by the designer: the address map and the APB register port.
`include "fesl_consts.vh"
`default_nettype none
module fesl_sequencer (
	// APB slave
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	// Device pins, asynchronous
	input wire ce_n,
	input wire wp_n,
	input wire vpp_lockout,
	// Device state
	output reg busy,
	output reg standby
);
	localparam NBLK = 8;
	localparam [4:0] S_IDLE = 5'h01;
	localparam [4:0] S_ERASE = 5'h02;
	localparam [4:0] S_ESUSP = 5'h04;
	localparam [4:0] S_PROG = 5'h08;
	localparam [4:0] S_PSUSP = 5'h10;
	localparam [3:0] Q_NONE = 4'h1;
	localparam [3:0] Q_PROG = 4'h2;
	localparam [3:0] Q_ERASE = 4'h4;
	localparam [3:0] Q_LOCK = 4'h8;
	localparam [3:0] M_ARRAY = 4'h1;
	localparam [3:0] M_STATUS = 4'h2;
	localparam [3:0] M_ID = 4'h4;
	localparam [3:0] M_CFI = 4'h8;
	localparam [11:0] PROG_CYC = `FESL_PROG_CYC;
	localparam [11:0] ERASE_CYC = `FESL_ERASE_CYC;
	localparam [11:0] SUSP_CYC = `FESL_SUSP_CYC;

	function is_read_cmd;
		input [7:0] c;
		begin
			is_read_cmd = (c == `FESL_C_READ_ARRAY) || (c == `FESL_C_READ_STATUS) ||
				(c == `FESL_C_READ_ID) || (c == `FESL_C_CFI);
		end
	endfunction

	function [3:0] read_mode;
		input [7:0] c;
		begin
			case (c)
				`FESL_C_READ_ARRAY: read_mode = M_ARRAY;
				`FESL_C_READ_ID: read_mode = M_ID;
				`FESL_C_CFI: read_mode = M_CFI;
				default: read_mode = M_STATUS;
			endcase
		end
	endfunction

	reg [1:0] ce_sy_r;
	reg [1:0] wp_sy_r;
	reg [1:0] vpp_sy_r;
	reg [4:0] state_r;
	reg [3:0] seq_r;
	reg [3:0] mode_r;
	reg [2:0] rd_blk_r;
	reg [2:0] erase_blk_r;
	reg [2:0] prog_blk_r;
	reg [2:0] setup_blk_r;
	reg [11:0] erase_cnt_r;
	reg [11:0] prog_cnt_r;
	reg [11:0] susp_cnt_r;
	reg susp_req_r;
	reg prog_in_es_r;
	reg err_erase_r;
	reg err_prog_r;
	reg err_vpp_r;
	reg err_lock_r;
	reg [NBLK-1:0] erased_r;
	reg [15:0] rcr_r;
	wire ce_off;
	wire wp_on;
	wire vpp_low;
	wire acc;
	wire wr_cmd;
	wire [7:0] code;
	wire [2:0] blk;
	wire [15:0] dat;
	wire [NBLK-1:0] lock_w;
	wire [NBLK-1:0] lockdn_w;
	wire [7:0] sr;
	reg [31:0] rd_word;

	assign ce_off = ce_sy_r[1];
	assign wp_on = ~wp_sy_r[1];
	assign vpp_low = vpp_sy_r[1];
	assign acc = psel & penable & pready;
	assign wr_cmd = acc & pwrite & (paddr == `FESL_REG_CMD) & ~ce_off;
	assign code = pwdata[`FESL_CODE_MSB:0];
	assign blk = pwdata[`FESL_BLK_MSB:`FESL_BLK_LSB];
	assign dat = pwdata[31:`FESL_DAT_LSB];

	assign sr[`FESL_SR_READY] = ~(state_r[1] | state_r[3]);
	assign sr[`FESL_SR_ESUSP] = state_r[2] | (state_r[4] & prog_in_es_r);
	assign sr[`FESL_SR_ERASE_ERR] = err_erase_r;
	assign sr[`FESL_SR_PROG_ERR] = err_prog_r;
	assign sr[`FESL_SR_VPP_ERR] = err_vpp_r;
	assign sr[`FESL_SR_PSUSP] = state_r[4];
	assign sr[`FESL_SR_LOCK_ERR] = err_lock_r;
	assign sr[`FESL_SR_ERASING] = state_r[1] & (rd_blk_r == erase_blk_r);

	// Pin synchronisers
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ce_sy_r <= 2'h3;
			wp_sy_r <= 2'h0;
			vpp_sy_r <= 2'h0;
		end
		else
		begin
			ce_sy_r <= {ce_sy_r[0], ce_n};
			wp_sy_r <= {wp_sy_r[0], wp_n};
			vpp_sy_r <= {vpp_sy_r[0], vpp_lockout};
		end
	end

	// Per-block lock and lock-down bits
	genvar g;
	generate
		for (g = 0; g < NBLK; g = g + 1)
		begin : g_lock
			reg lock_r;
			reg lockdn_r;
			wire hit;
			assign hit = wr_cmd & seq_r[3] & (blk == g);
			always @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					lock_r <= |(`FESL_LOCK_RST & (8'h01 << g));
					lockdn_r <= 1'b0;
				end
				else if (hit)
				begin
					if (code == `FESL_C_LOCK)
						lock_r <= 1'b1;
					else if (code == `FESL_C_LOCKDN)
						{lock_r, lockdn_r} <= 2'h3;
					else if (code == `FESL_C_CONFIRM && !(lockdn_r && wp_on))
						lock_r <= 1'b0;
				end
			end
			assign lock_w[g] = lock_r;
			assign lockdn_w[g] = lockdn_r;
		end
	endgenerate

	// Command sequencer and internal write sequencer
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_r <= S_IDLE;
			seq_r <= Q_NONE;
			mode_r <= M_ARRAY;
			{erase_blk_r, prog_blk_r, setup_blk_r} <= 9'h000;
			{erase_cnt_r, prog_cnt_r, susp_cnt_r} <= 36'h000000000;
			{susp_req_r, prog_in_es_r} <= 2'h0;
			{err_erase_r, err_prog_r, err_vpp_r, err_lock_r} <= 4'h0;
			erased_r <= {NBLK{1'b0}};
			rcr_r <= `FESL_RCR_RST;
		end
		else
		begin
			case (state_r)
				S_ERASE:
				begin
					if (vpp_low)
					begin
						{err_vpp_r, err_erase_r} <= 2'h3;
						susp_req_r <= 1'b0;
						state_r <= S_IDLE;
					end
					else if (susp_req_r)
					begin
						if (susp_cnt_r == 12'h001)
						begin
							susp_req_r <= 1'b0;
							state_r <= S_ESUSP;
						end
						susp_cnt_r <= susp_cnt_r - 12'h001;
					end
					else if (erase_cnt_r == 12'h001)
					begin
						erased_r[erase_blk_r] <= 1'b1;
						state_r <= S_IDLE;
					end
					erase_cnt_r <= erase_cnt_r - {11'h000, ~susp_req_r};
				end
				S_PROG:
				begin
					if (vpp_low)
					begin
						{err_vpp_r, err_prog_r} <= 2'h3;
						susp_req_r <= 1'b0;
						state_r <= prog_in_es_r ? S_ESUSP : S_IDLE;
						prog_in_es_r <= 1'b0;
					end
					else if (susp_req_r)
					begin
						if (susp_cnt_r == 12'h001)
						begin
							susp_req_r <= 1'b0;
							state_r <= S_PSUSP;
						end
						susp_cnt_r <= susp_cnt_r - 12'h001;
					end
					else if (prog_cnt_r == 12'h001)
					begin
						erased_r[prog_blk_r] <= 1'b0;
						state_r <= prog_in_es_r ? S_ESUSP : S_IDLE;
						prog_in_es_r <= 1'b0;
					end
					prog_cnt_r <= prog_cnt_r - {11'h000, ~susp_req_r};
				end
				default:
					susp_req_r <= 1'b0;
			endcase

			if (wr_cmd)
			begin
				seq_r <= Q_NONE;
				if (seq_r[3])
				begin
					if (code == `FESL_C_RCR_SET)
						rcr_r <= dat;
					else if (code != `FESL_C_LOCK && code != `FESL_C_LOCKDN &&
						code != `FESL_C_CONFIRM)
						{err_prog_r, err_erase_r} <= 2'h3;
				end
				else if (seq_r[1])
				begin
					mode_r <= M_STATUS;
					if (lock_w[blk])
						{err_prog_r, err_lock_r} <= 2'h3;
					else if (vpp_low)
						{err_prog_r, err_vpp_r} <= 2'h3;
					else if (state_r[2] && blk == erase_blk_r)
						err_prog_r <= 1'b1;
					else
					begin
						prog_in_es_r <= state_r[2];
						prog_blk_r <= blk;
						prog_cnt_r <= PROG_CYC;
						state_r <= S_PROG;
					end
				end
				else if (seq_r[2])
				begin
					mode_r <= M_STATUS;
					if (code != `FESL_C_CONFIRM || blk != setup_blk_r)
						{err_prog_r, err_erase_r} <= 2'h3;
					else if (lock_w[blk])
						{err_erase_r, err_lock_r} <= 2'h3;
					else if (vpp_low)
						{err_erase_r, err_vpp_r} <= 2'h3;
					else
					begin
						erase_blk_r <= blk;
						erase_cnt_r <= ERASE_CYC;
						state_r <= S_ERASE;
					end
				end
				else if (state_r[0] || state_r[2])
				begin
					if (is_read_cmd(code))
						mode_r <= read_mode(code);
					else if (code == `FESL_C_CLR_STATUS)
						{err_erase_r, err_prog_r, err_vpp_r, err_lock_r} <= 4'h0;
					else if (code == `FESL_C_PROG_SETUP || code == `FESL_C_PROG_ALT)
						seq_r <= Q_PROG;
					else if (code == `FESL_C_LOCK_SETUP)
						seq_r <= Q_LOCK;
					else if (code == `FESL_C_ERASE_SETUP && state_r[0])
					begin
						seq_r <= Q_ERASE;
						setup_blk_r <= blk;
						mode_r <= M_STATUS;
					end
					else if (code == `FESL_C_CONFIRM && state_r[2])
					begin
						state_r <= S_ERASE;
						mode_r <= M_STATUS;
					end
				end
				else if (state_r[4])
				begin
					if (is_read_cmd(code))
						mode_r <= read_mode(code);
					else if (code == `FESL_C_CONFIRM)
					begin
						state_r <= S_PROG;
						mode_r <= M_STATUS;
					end
				end
				else if (code == `FESL_C_SUSPEND && !susp_req_r)
				begin
					susp_req_r <= 1'b1;
					susp_cnt_r <= SUSP_CYC;
				end
			end
		end
	end

	// Data the device drives on a read cycle
	always @*
	begin
		rd_word = 32'h00000000;
		case (mode_r)
			M_ARRAY:
				if (state_r[2] && rd_blk_r == erase_blk_r)
					rd_word = {24'h000000, sr};
				else
					rd_word = {16'h0000, {16{erased_r[rd_blk_r]}}};
			M_ID: rd_word = {30'h00000000, lockdn_w[rd_blk_r], lock_w[rd_blk_r]};
			M_CFI: rd_word = {16'h0000, `FESL_CFI_WORD};
			default: rd_word = {24'h000000, sr};
		endcase
	end

	// APB slave: one wait state, registered answer
	always @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
			rd_blk_r <= 3'h0;
			busy <= 1'b0;
			standby <= 1'b0;
		end
		else
		begin
			pready <= psel & penable & ~pready;
			busy <= state_r[1] | state_r[3];
			standby <= ce_off & ~(state_r[1] | state_r[3]);
			if (acc & pwrite & (paddr == `FESL_REG_ADDR))
				rd_blk_r <= pwdata[2:0];
			pslverr <= psel && penable && !pready && (paddr != `FESL_REG_CMD) &&
				(paddr != `FESL_REG_ADDR) && (paddr != `FESL_REG_RDATA) &&
				(paddr != `FESL_REG_STATUS) && (paddr != `FESL_REG_RCR) &&
				(paddr != `FESL_REG_PINS);
			if (psel & penable & ~pready)
			begin
				case (paddr)
					`FESL_REG_ADDR: prdata <= {29'h00000000, rd_blk_r};
					`FESL_REG_RDATA: prdata <= rd_word;
					`FESL_REG_STATUS: prdata <= {24'h000000, sr};
					`FESL_REG_RCR: prdata <= {16'h0000, rcr_r};
					`FESL_REG_PINS: prdata <= {24'h000000, seq_r, vpp_low, ~wp_on, ce_off, 1'b0};
					default: prdata <= 32'h00000000;
				endcase
			end
		end
	end
endmodule // fesl_sequencer
`default_nettype wire

//--- fesl_sequencer_properties.sv
`default_nettype none
module fesl_seq_checker (
	// APB
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Pins and state
	input wire logic ce_n,
	input wire logic wp_n,
	input wire logic vpp_lockout,
	input wire logic busy,
	input wire logic standby
);
	logic [2:0] low_cnt_r;
	logic rd_st;
	logic wr_susp;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Cycles that chip enable has been held asserted, saturating
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			low_cnt_r <= 3'h0;
		else if (ce_n)
			low_cnt_r <= 3'h0;
		else if (low_cnt_r != 3'h7)
			low_cnt_r <= low_cnt_r + 3'h1;
	assign rd_st = psel && penable && pready && !pwrite && paddr == 8'h0C;
	assign wr_susp = psel && penable && pready && pwrite && paddr == 8'h00
		&& pwdata[7:0] == 8'hB0;
	property p_wait;
		psel && !penable |=> ##1 pready;
	endproperty
	a_wait: assert property (p_wait) else $error("no answer in second access cycle");
	property p_pulse;
		pready |=> !pready;
	endproperty
	a_pulse: assert property (p_pulse) else $error("pready longer than one cycle");
	property p_err;
		pslverr |-> pready;
	endproperty
	a_err: assert property (p_err) else $error("pslverr without pready");
	property p_busy_sb;
		busy |-> !standby;
	endproperty
	a_busy_sb: assert property (p_busy_sb) else $error("standby while busy");
	property p_sel_sb;
		low_cnt_r == 3'h7 |-> !standby;
	endproperty
	a_sel_sb: assert property (p_sel_sb) else $error("standby while selected");
	property p_susp;
		wr_susp && busy && low_cnt_r == 3'h7 |-> ##[1:25] !busy;
	endproperty
	a_susp: assert property (p_susp) else $error("suspend not taken");
	property p_vpp;
		vpp_lockout && $past(vpp_lockout) && $past(vpp_lockout, 2) && busy |-> ##[0:5] !busy;
	endproperty
	a_vpp: assert property (p_vpp) else $error("low supply did not halt");
	property p_stat;
		rd_st && busy && $past(busy) |-> !prdata[7];
	endproperty
	a_stat: assert property (p_stat) else $error("ready shown while busy");
endmodule // fesl_seq_checker
bind fesl_sequencer fesl_seq_checker chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .prdata, .pready, .pslverr, .ce_n, .wp_n, .vpp_lockout, .busy, .standby);
`default_nettype wire

//--- fesl_sequencer_tb_top.sv
`default_nettype none
module fesl_sequencer_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk = 1'b0, presetn = 1'b0, ce_n = 1'b0, wp_n = 1'b0, vpp_lockout = 1'b0;
	logic req = 1'b0, wr = 1'b0, ack, err, psel, penable, pwrite, pready, pslverr, busy, standby;
	logic [7:0] addr = 8'h00, paddr;
	logic [31:0] wdata = 32'h0, rdata, pwdata, prdata;
	int num_errors = 0, cmp_count = 0, cyc = 0;
	initial
		forever #10 pclk = ~pclk;
	fesl_host host (.pclk, .req, .wr, .addr, .wdata, .ack, .rdata, .err, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
	fesl_sequencer dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .ce_n, .wp_n, .vpp_lockout, .busy, .standby);
	task automatic final_report;
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	always @(posedge pclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 40000)
		begin
			num_errors++;
			final_report;
		end
	end
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		wr <= w;
		addr <= a;
		wdata <= d;
		req <= ~req;
		@(posedge pclk);
		while (ack !== req)
			@(posedge pclk);
	endtask
	task automatic cmd(input logic [7:0] c, input logic [2:0] b);
		bus(1'b1, 8'h00, {21'h0, b, c});
	endtask
	// Offsets above the pin register are unmapped
	task automatic chk(input logic [7:0] a, input logic [31:0] e);
		bus(1'b0, a, 32'h0);
		cmp_count++;
		if (rdata !== e || err !== (a > 8'h14))
		begin
			num_errors++;
			$display("ERROR %0t read %h got %h exp %h", $time, a, rdata, e);
		end
	endtask
	task automatic chk_lvl(input logic got, input logic e);
		cmp_count++;
		if (got !== e)
		begin
			num_errors++;
			$display("ERROR %0t level got %b exp %b", $time, got, e);
		end
	endtask
	task automatic wait_rdy;
		do
			bus(1'b0, 8'h0C, 32'h0);
		while (rdata[7] !== 1'b1);
	endtask
	task automatic idq(input logic [2:0] b, input logic [31:0] e);
		bus(1'b1, 8'h04, {29'h0, b});
		cmd(8'h90, b);
		chk(8'h08, e);
	endtask
	task automatic ers(input logic [2:0] b);
		cmd(8'h20, b);
		cmd(8'hD0, b);
	endtask
	task automatic t_reset;
		chk(8'h0C, 32'h80);
		chk(8'h3C, 32'h0);
		cmd(8'h60, 3'h0);
		bus(1'b1, 8'h00, 32'h5A3C_0003);
		chk(8'h10, 32'h5A3C);
		idq(3'h3, 32'h1);
		ers(3'h3);
		wait_rdy;
		chk(8'h0C, 32'hA2);
		cmd(8'h50, 3'h0);
	endtask
	task automatic t_erase;
		cmd(8'h60, 3'h2);
		cmd(8'hD0, 3'h2);
		idq(3'h2, 32'h0);
		ers(3'h2);
		ce_n <= 1'b1;
		chk(8'h08, 32'h01);
		chk_lvl(busy, 1'b1);
		chk_lvl(standby, 1'b0);
		wait_rdy;
		chk(8'h08, 32'h80);
		chk_lvl(standby, 1'b1);
		ce_n <= 1'b0;
		repeat (3) @(posedge pclk);
		cmd(8'hFF, 3'h0);
		chk_lvl(standby, 1'b0);
		chk(8'h08, 32'hFFFF);
		bus(1'b1, 8'h04, 32'h1);
		chk(8'h08, 32'h0);
	endtask
	task automatic t_susp;
		cmd(8'h60, 3'h4);
		cmd(8'hD0, 3'h4);
		cmd(8'h60, 3'h5);
		cmd(8'hD0, 3'h5);
		ers(3'h4);
		cmd(8'hB0, 3'h7);
		wait_rdy;
		bus(1'b1, 8'h04, 32'h5);
		chk(8'h0C, 32'hC0);
		cmd(8'h60, 3'h4);
		cmd(8'h01, 3'h4);
		idq(3'h4, 32'h1);
		bus(1'b1, 8'h04, 32'h5);
		cmd(8'h40, 3'h5);
		cmd(8'h00, 3'h5);
		cmd(8'hD0, 3'h6);
		wait_rdy;
		chk(8'h0C, 32'hC0);
		cmd(8'hD0, 3'h1);
		chk(8'h0C, 32'h00);
		wait_rdy;
		chk(8'h0C, 32'h80);
		cmd(8'hFF, 3'h0);
		chk(8'h08, 32'h0);
		bus(1'b1, 8'h04, 32'h4);
		chk(8'h08, 32'hFFFF);
	endtask
	task automatic t_err;
		cmd(8'h60, 3'h0);
		cmd(8'hFF, 3'h0);
		vpp_lockout <= 1'b1;
		cmd(8'h60, 3'h6);
		cmd(8'hD0, 3'h6);
		idq(3'h6, 32'h0);
		chk(8'h0C, 32'hB0);
		vpp_lockout <= 1'b0;
		cmd(8'h50, 3'h0);
		ers(3'h6);
		vpp_lockout <= 1'b1;
		wait_rdy;
		chk(8'h0C, 32'hA8);
		vpp_lockout <= 1'b0;
		cmd(8'h50, 3'h0);
		chk(8'h0C, 32'h80);
		cmd(8'h40, 3'h2);
		cmd(8'h00, 3'h2);
		cmd(8'hB0, 3'h7);
		wait_rdy;
		chk(8'h0C, 32'h84);
		cmd(8'h60, 3'h2);
		cmd(8'h01, 3'h2);
		idq(3'h2, 32'h0);
		cmd(8'hD0, 3'h5);
		chk(8'h0C, 32'h00);
		wait_rdy;
		chk(8'h0C, 32'h80);
	endtask
	task automatic t_down;
		cmd(8'h60, 3'h1);
		cmd(8'h2F, 3'h1);
		cmd(8'h60, 3'h1);
		cmd(8'hD0, 3'h1);
		idq(3'h1, 32'h3);
		wp_n <= 1'b1;
		cmd(8'h60, 3'h1);
		cmd(8'hD0, 3'h1);
		idq(3'h1, 32'h2);
		ers(3'h1);
		cmd(8'hB0, 3'h1);
		wait_rdy;
		chk(8'h0C, 32'hC0);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		chk(8'h0C, 32'h80);
		idq(3'h1, 32'h1);
	endtask
	initial
	begin
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		t_reset;
		t_erase;
		t_susp;
		t_err;
		t_down;
		final_report;
	end
endmodule // fesl_sequencer_tb_top
`default_nettype wire
